// ===== design/cid_decode_core.sv
// instruction decode, operand collection and execution timing
//
// Function
// - every instruction is 1, 2 or 3 bytes; operands fetched before next opcode
// - each instruction runs at least its table count of 2 to 32 cycles, more while operand bytes arrive late
// - add to accumulator: 28-2F, 25, 26-27, 24, two cycles
// - add with carry: 38-3F, 35, 36-37, 34, two cycles
// - subtract with borrow: 98-9F, 95, 96-97, 94, two cycles
// - AND group 58-5F, 55, 56-57, 54, 52 two cycles; 53 three bytes, four
// - OR group 48-4F, 45, 46-47, 44, 42 two cycles; 43 three bytes, four
// - XOR group 68-6F, 65, 66-67, 64, 62 two cycles; 63 three bytes, four
// - rotates 23, 33, 03, 13 take two cycles; 33 and 13 use carry
// - loads to accumulator E8-EF, E5, E6-E7, 74 take two cycles
// - register writes F8-FF and 78-7F two cycles, A8-AF four cycles
// - direct writes F5 two cycles; 88-8F, 86-87, 85, 75 four; 85, 75 three bytes
// - indirect writes F6-F7, 76-77 two cycles, A6-A7 four cycles
// - 90 loads data pointer, three bytes, four cycles
// - code reads 93 and 83 are one byte, eight cycles
// - external reads E2-E3, E0 and writes F2-F3, F0 take eight cycles
// - push C0 and pop D0 are two bytes, four cycles
// - exchanges C8-CF, C5, C6-C7 full byte, D6-D7 low nibble, two cycles
// - carry logic 82, B0, 72, A0 take four cycles
// - A2 bit to carry two cycles, 92 carry to bit four cycles, two bytes
// - wide select clear gives 8-bit mul/div, set gives 16-bit forms
// - in wide mode long divide select picks 16/16 or 32/16 divide
// - eight-wide opcode blocks take register number from low three bits
`timescale 1ns/1ps
module cid_decode_core (
	input logic ref_clk,
	input logic rst,
	input logic [cid_pkg::OPC_W-1:0] codeByte,
	input logic codeValid,
	output logic codeReady,
	input logic wideMuldivSelect,
	input logic longDivideSelect,
	output logic [cid_pkg::OPC_W-1:0] opcode,
	output logic [cid_pkg::OPC_W-1:0] operandOne,
	output logic [cid_pkg::OPC_W-1:0] operandTwo,
	output cid_pkg::cid_op_t opKind,
	output cid_pkg::cid_am_t srcMode,
	output cid_pkg::cid_am_t dstMode,
	output logic [cid_pkg::LEN_W-1:0] instLength,
	output logic [cid_pkg::CYC_W-1:0] instCycles,
	output logic [cid_pkg::REG_W-1:0] regSel,
	output logic indSel,
	output logic usesCarry,
	output logic busy,
	output logic instDone
);
	import cid_pkg::*;

	// ----------------------------------------
	// state and holding registers
	// ----------------------------------------
	typedef enum logic [1:0] {ST_FETCH, ST_OPER1, ST_OPER2, ST_EXEC} cid_state_t;
	cid_state_t state_q;
	cid_state_t state_d;
	cid_entry_t ent;
	cid_entry_t ent_q;
	logic [OPC_W-1:0] opcode_q;
	logic [REG_W-1:0] regSel_q;
	logic indSel_q;
	logic usesCarry_q;
	logic takeOpc;
	logic takeOp1;
	logic takeOp2;
	logic expired;
	logic [CYC_W-1:0] mulCyc;
	logic [CYC_W-1:0] divCyc;
	logic carryUse;
	logic [CYC_W-1:0] timerLoad;
	logic shortInst;
	logic longInst;
	cid_entry_t entIdle;

	// ----------------------------------------
	// multiply and divide timing by mode
	// ----------------------------------------
	assign mulCyc = wideMuldivSelect ? CYC_16 : CYC_8;
	assign divCyc = !wideMuldivSelect ? CYC_8 : (longDivideSelect ? CYC_32 : CYC_16);

	// ----------------------------------------
	// idle entry and length decode
	// ----------------------------------------
	assign entIdle = mk(OP_OTHER, AM_NONE, AM_NONE, LEN_1, CYC_2);
	assign shortInst = (ent.len == LEN_1);
	assign longInst = (ent_q.len == LEN_3);

	// ----------------------------------------
	// cycle timer load
	// ----------------------------------------
	// take cycle and done cycle both count
	assign timerLoad = ent.cyc - CYC_2;

	// ----------------------------------------
	// opcode table
	// ----------------------------------------
	always_comb begin
		ent = entIdle;
		unique casez (codeByte)
			8'b0010_1???: ent = mk(OP_ADD, AM_REG, AM_ACC, LEN_1, CYC_2);
			8'h25: ent = mk(OP_ADD, AM_DIR, AM_ACC, LEN_2, CYC_2);
			8'b0010_011?: ent = mk(OP_ADD, AM_IND, AM_ACC, LEN_1, CYC_2);
			8'h24: ent = mk(OP_ADD, AM_IMM, AM_ACC, LEN_2, CYC_2);
			8'b0011_1???: ent = mk(OP_ADDC, AM_REG, AM_ACC, LEN_1, CYC_2);
			8'h35: ent = mk(OP_ADDC, AM_DIR, AM_ACC, LEN_2, CYC_2);
			8'b0011_011?: ent = mk(OP_ADDC, AM_IND, AM_ACC, LEN_1, CYC_2);
			8'h34: ent = mk(OP_ADDC, AM_IMM, AM_ACC, LEN_2, CYC_2);
			8'b1001_1???: ent = mk(OP_SUBB, AM_REG, AM_ACC, LEN_1, CYC_2);
			8'h95: ent = mk(OP_SUBB, AM_DIR, AM_ACC, LEN_2, CYC_2);
			8'b1001_011?: ent = mk(OP_SUBB, AM_IND, AM_ACC, LEN_1, CYC_2);
			8'h94: ent = mk(OP_SUBB, AM_IMM, AM_ACC, LEN_2, CYC_2);
			8'h04: ent = mk(OP_INC, AM_ACC, AM_ACC, LEN_1, CYC_2);
			8'b0000_1???: ent = mk(OP_INC, AM_REG, AM_REG, LEN_1, CYC_2);
			8'h05: ent = mk(OP_INC, AM_DIR, AM_DIR, LEN_2, CYC_2);
			8'b0000_011?: ent = mk(OP_INC, AM_IND, AM_IND, LEN_1, CYC_2);
			8'h14: ent = mk(OP_DEC, AM_ACC, AM_ACC, LEN_1, CYC_2);
			8'b0001_1???: ent = mk(OP_DEC, AM_REG, AM_REG, LEN_1, CYC_2);
			8'h15: ent = mk(OP_DEC, AM_DIR, AM_DIR, LEN_2, CYC_2);
			8'b0001_011?: ent = mk(OP_DEC, AM_IND, AM_IND, LEN_1, CYC_2);
			8'hA3: ent = mk(OP_INC, AM_DPTR, AM_DPTR, LEN_1, CYC_4);
			8'hA4: ent = mk(OP_MUL, AM_AB, AM_AB, LEN_1, mulCyc);
			8'h84: ent = mk(OP_DIV, AM_AB, AM_AB, LEN_1, divCyc);
			8'hD4: ent = mk(OP_DA, AM_ACC, AM_ACC, LEN_1, CYC_2);
			8'b0101_1???: ent = mk(OP_ANL, AM_REG, AM_ACC, LEN_1, CYC_2);
			8'h55: ent = mk(OP_ANL, AM_DIR, AM_ACC, LEN_2, CYC_2);
			8'b0101_011?: ent = mk(OP_ANL, AM_IND, AM_ACC, LEN_1, CYC_2);
			8'h54: ent = mk(OP_ANL, AM_IMM, AM_ACC, LEN_2, CYC_2);
			8'h52: ent = mk(OP_ANL, AM_ACC, AM_DIR, LEN_2, CYC_2);
			8'h53: ent = mk(OP_ANL, AM_IMM, AM_DIR, LEN_3, CYC_4);
			8'b0100_1???: ent = mk(OP_ORL, AM_REG, AM_ACC, LEN_1, CYC_2);
			8'h45: ent = mk(OP_ORL, AM_DIR, AM_ACC, LEN_2, CYC_2);
			8'b0100_011?: ent = mk(OP_ORL, AM_IND, AM_ACC, LEN_1, CYC_2);
			8'h44: ent = mk(OP_ORL, AM_IMM, AM_ACC, LEN_2, CYC_2);
			8'h42: ent = mk(OP_ORL, AM_ACC, AM_DIR, LEN_2, CYC_2);
			8'h43: ent = mk(OP_ORL, AM_IMM, AM_DIR, LEN_3, CYC_4);
			8'b0110_1???: ent = mk(OP_XRL, AM_REG, AM_ACC, LEN_1, CYC_2);
			8'h65: ent = mk(OP_XRL, AM_DIR, AM_ACC, LEN_2, CYC_2);
			8'b0110_011?: ent = mk(OP_XRL, AM_IND, AM_ACC, LEN_1, CYC_2);
			8'h64: ent = mk(OP_XRL, AM_IMM, AM_ACC, LEN_2, CYC_2);
			8'h62: ent = mk(OP_XRL, AM_ACC, AM_DIR, LEN_2, CYC_2);
			8'h63: ent = mk(OP_XRL, AM_IMM, AM_DIR, LEN_3, CYC_4);
			8'hE4: ent = mk(OP_CLR, AM_NONE, AM_ACC, LEN_1, CYC_2);
			8'hF4: ent = mk(OP_CPL, AM_ACC, AM_ACC, LEN_1, CYC_2);
			8'hC4: ent = mk(OP_SWAP, AM_ACC, AM_ACC, LEN_1, CYC_2);
			8'h23: ent = mk(OP_RL, AM_ACC, AM_ACC, LEN_1, CYC_2);
			8'h33: ent = mk(OP_RLC, AM_ACC, AM_ACC, LEN_1, CYC_2);
			8'h03: ent = mk(OP_RR, AM_ACC, AM_ACC, LEN_1, CYC_2);
			8'h13: ent = mk(OP_RRC, AM_ACC, AM_ACC, LEN_1, CYC_2);
			8'b1110_1???: ent = mk(OP_MOV, AM_REG, AM_ACC, LEN_1, CYC_2);
			8'hE5: ent = mk(OP_MOV, AM_DIR, AM_ACC, LEN_2, CYC_2);
			8'b1110_011?: ent = mk(OP_MOV, AM_IND, AM_ACC, LEN_1, CYC_2);
			8'h74: ent = mk(OP_MOV, AM_IMM, AM_ACC, LEN_2, CYC_2);
			8'b1111_1???: ent = mk(OP_MOV, AM_ACC, AM_REG, LEN_1, CYC_2);
			8'b1010_1???: ent = mk(OP_MOV, AM_DIR, AM_REG, LEN_2, CYC_4);
			8'b0111_1???: ent = mk(OP_MOV, AM_IMM, AM_REG, LEN_2, CYC_2);
			8'hF5: ent = mk(OP_MOV, AM_ACC, AM_DIR, LEN_2, CYC_2);
			8'b1000_1???: ent = mk(OP_MOV, AM_REG, AM_DIR, LEN_2, CYC_4);
			8'h85: ent = mk(OP_MOV, AM_DIR, AM_DIR, LEN_3, CYC_4);
			8'b1000_011?: ent = mk(OP_MOV, AM_IND, AM_DIR, LEN_2, CYC_4);
			8'h75: ent = mk(OP_MOV, AM_IMM, AM_DIR, LEN_3, CYC_4);
			8'b1111_011?: ent = mk(OP_MOV, AM_ACC, AM_IND, LEN_1, CYC_2);
			8'b1010_011?: ent = mk(OP_MOV, AM_DIR, AM_IND, LEN_2, CYC_4);
			8'b0111_011?: ent = mk(OP_MOV, AM_IMM, AM_IND, LEN_2, CYC_2);
			8'h90: ent = mk(OP_MOV, AM_IMM, AM_DPTR, LEN_3, CYC_4);
			8'h93: ent = mk(OP_MOVC, AM_CODE_DPTR, AM_ACC, LEN_1, CYC_8);
			8'h83: ent = mk(OP_MOVC, AM_CODE_PC, AM_ACC, LEN_1, CYC_8);
			8'b1110_001?: ent = mk(OP_MOVX, AM_EXT_IND, AM_ACC, LEN_1, CYC_8);
			8'hE0: ent = mk(OP_MOVX, AM_EXT_DPTR, AM_ACC, LEN_1, CYC_8);
			8'b1111_001?: ent = mk(OP_MOVX, AM_ACC, AM_EXT_IND, LEN_1, CYC_8);
			8'hF0: ent = mk(OP_MOVX, AM_ACC, AM_EXT_DPTR, LEN_1, CYC_8);
			8'hC0: ent = mk(OP_PUSH, AM_DIR, AM_STACK, LEN_2, CYC_4);
			8'hD0: ent = mk(OP_POP, AM_STACK, AM_DIR, LEN_2, CYC_4);
			8'b1100_1???: ent = mk(OP_XCH, AM_REG, AM_ACC, LEN_1, CYC_2);
			8'hC5: ent = mk(OP_XCH, AM_DIR, AM_ACC, LEN_2, CYC_2);
			8'b1100_011?: ent = mk(OP_XCH, AM_IND, AM_ACC, LEN_1, CYC_2);
			8'b1101_011?: ent = mk(OP_XCHD, AM_IND, AM_ACC, LEN_1, CYC_2);
			8'hC3: ent = mk(OP_CLR, AM_NONE, AM_CARRY, LEN_1, CYC_2);
			8'hC2: ent = mk(OP_CLR, AM_NONE, AM_BIT, LEN_2, CYC_2);
			8'hD3: ent = mk(OP_SETB, AM_NONE, AM_CARRY, LEN_1, CYC_2);
			8'hD2: ent = mk(OP_SETB, AM_NONE, AM_BIT, LEN_2, CYC_2);
			8'hB3: ent = mk(OP_CPL, AM_CARRY, AM_CARRY, LEN_1, CYC_2);
			8'hB2: ent = mk(OP_CPL, AM_BIT, AM_BIT, LEN_2, CYC_2);
			8'h82: ent = mk(OP_ANL, AM_BIT, AM_CARRY, LEN_2, CYC_4);
			8'hB0: ent = mk(OP_ANLN, AM_BIT, AM_CARRY, LEN_2, CYC_4);
			8'h72: ent = mk(OP_ORL, AM_BIT, AM_CARRY, LEN_2, CYC_4);
			8'hA0: ent = mk(OP_ORLN, AM_BIT, AM_CARRY, LEN_2, CYC_4);
			8'hA2: ent = mk(OP_MOV, AM_BIT, AM_CARRY, LEN_2, CYC_2);
			8'h92: ent = mk(OP_MOV, AM_CARRY, AM_BIT, LEN_2, CYC_4);
			default: ent = entIdle;
		endcase
	end

	// ----------------------------------------
	// carry involvement
	// ----------------------------------------
	assign carryUse = (ent.kind == OP_ADDC) || (ent.kind == OP_SUBB)
		|| (ent.kind == OP_RLC) || (ent.kind == OP_RRC)
		|| (ent.src == AM_CARRY) || (ent.dst == AM_CARRY);

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	assign codeReady = (state_q != ST_EXEC);
	assign takeOpc = codeValid && (state_q == ST_FETCH);
	assign takeOp1 = codeValid && (state_q == ST_OPER1);
	assign takeOp2 = codeValid && (state_q == ST_OPER2);
	assign instDone = (state_q == ST_EXEC) && expired;
	assign busy = (state_q != ST_FETCH);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_FETCH: begin
				if (takeOpc) begin
					state_d = shortInst ? ST_EXEC : ST_OPER1;
				end
			end
			ST_OPER1: begin
				if (takeOp1) begin
					state_d = longInst ? ST_OPER2 : ST_EXEC;
				end
			end
			ST_OPER2: begin
				if (takeOp2) begin
					state_d = ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (instDone) begin
					state_d = ST_FETCH;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_FETCH;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------
	// decoded instruction hold
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ent_q <= mk(OP_OTHER, AM_NONE, AM_NONE, LEN_1, CYC_2);
			opcode_q <= BYTE_RST;
			regSel_q <= '0;
			indSel_q <= 1'b0;
			usesCarry_q <= 1'b0;
		end else if (takeOpc) begin
			ent_q <= ent;
			opcode_q <= codeByte;
			regSel_q <= codeByte[REG_LSB +: REG_W];
			indSel_q <= codeByte[IND_BIT];
			usesCarry_q <= carryUse;
		end
	end

	assign opcode = opcode_q;
	assign opKind = ent_q.kind;
	assign srcMode = ent_q.src;
	assign dstMode = ent_q.dst;
	assign instLength = ent_q.len;
	assign instCycles = ent_q.cyc;
	assign regSel = regSel_q;
	assign indSel = indSel_q;
	assign usesCarry = usesCarry_q;

	// ----------------------------------------
	// operand bytes and cycle timer
	// ----------------------------------------
	cid_byte_capture u_opOne (
		.ref_clk(ref_clk),
		.rst(rst),
		.clear(takeOpc),
		.take(takeOp1),
		.din(codeByte),
		.dout(operandOne)
	);

	cid_byte_capture u_opTwo (
		.ref_clk(ref_clk),
		.rst(rst),
		.clear(takeOpc),
		.take(takeOp2),
		.din(codeByte),
		.dout(operandTwo)
	);

	cid_cycle_timer #(
		.CW(CYC_W)
	) u_timer (
		.ref_clk(ref_clk),
		.rst(rst),
		.load(takeOpc),
		.loadCount(timerLoad),
		.expired(expired)
	);
endmodule : cid_decode_core

// ===== design/cid_pkg.sv
// constants, types and entry builder for the instruction decoder
package cid_pkg;
	localparam int OPC_W = 8;
	localparam int LEN_W = 2;
	localparam int CYC_W = 6;
	localparam int REG_LSB = 0;
	localparam int REG_W = 3;
	localparam int IND_BIT = 0;
	localparam logic [LEN_W-1:0] LEN_1 = 2'h1;
	localparam logic [LEN_W-1:0] LEN_2 = 2'h2;
	localparam logic [LEN_W-1:0] LEN_3 = 2'h3;
	localparam logic [CYC_W-1:0] CYC_2 = 6'h02;
	localparam logic [CYC_W-1:0] CYC_4 = 6'h04;
	localparam logic [CYC_W-1:0] CYC_8 = 6'h08;
	localparam logic [CYC_W-1:0] CYC_16 = 6'h10;
	localparam logic [CYC_W-1:0] CYC_32 = 6'h20;
	localparam logic [CYC_W-1:0] CYC_ONE = 6'h01;
	localparam logic [CYC_W-1:0] CYC_ZERO = 6'h00;
	localparam logic [OPC_W-1:0] BYTE_RST = 8'h00;

	typedef enum logic [4:0] {
		OP_OTHER, OP_ADD, OP_ADDC, OP_SUBB, OP_INC, OP_DEC, OP_MUL, OP_DIV, OP_DA,
		OP_ANL, OP_ORL, OP_XRL, OP_CLR, OP_CPL, OP_SWAP, OP_RL, OP_RLC, OP_RR, OP_RRC,
		OP_MOV, OP_MOVC, OP_MOVX, OP_PUSH, OP_POP, OP_XCH, OP_XCHD, OP_ANLN, OP_ORLN,
		OP_SETB
	} cid_op_t;

	typedef enum logic [3:0] {
		AM_NONE, AM_ACC, AM_REG, AM_DIR, AM_IND, AM_IMM, AM_BIT, AM_CARRY, AM_DPTR,
		AM_CODE_DPTR, AM_CODE_PC, AM_EXT_IND, AM_EXT_DPTR, AM_STACK, AM_AB
	} cid_am_t;

	typedef struct packed {
		cid_op_t kind;
		cid_am_t src;
		cid_am_t dst;
		logic [LEN_W-1:0] len;
		logic [CYC_W-1:0] cyc;
	} cid_entry_t;

	function automatic cid_entry_t mk(cid_op_t k, cid_am_t s, cid_am_t d,
		logic [LEN_W-1:0] l, logic [CYC_W-1:0] c);
		cid_entry_t e;
		e.kind = k;
		e.src = s;
		e.dst = d;
		e.len = l;
		e.cyc = c;
		return e;
	endfunction : mk
endpackage : cid_pkg

// ===== design/cid_cycle_timer.sv
// down counter of remaining execution cycles
`timescale 1ns/1ps
module cid_cycle_timer #(
	parameter int CW = cid_pkg::CYC_W
) (
	input logic ref_clk,
	input logic rst,
	input logic load,
	input logic [CW-1:0] loadCount,
	output logic expired
);
	import cid_pkg::*;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	assign expired = (cnt_q == '0);
	assign cnt_d = load ? loadCount : (expired ? cnt_q : cnt_q - CW'(1));
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule : cid_cycle_timer

// ===== design/cid_byte_capture.sv
// holding register for one fetched code byte
`timescale 1ns/1ps
module cid_byte_capture (
	input logic ref_clk,
	input logic rst,
	input logic clear,
	input logic take,
	input logic [cid_pkg::OPC_W-1:0] din,
	output logic [cid_pkg::OPC_W-1:0] dout
);
	import cid_pkg::*;
	logic [OPC_W-1:0] byte_q;
	assign dout = byte_q;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			byte_q <= BYTE_RST;
		end else if (take) begin
			byte_q <= din;
		end else if (clear) begin
			byte_q <= BYTE_RST;
		end
	end
endmodule : cid_byte_capture

// ===== dv/cid_decode_core_sva.sv
// checker of decoder take, timing and field relations
`timescale 1ns/1ps
module cid_decode_core_sva (
	input logic ref_clk,
	input logic rst,
	input logic [7:0] codeByte,
	input logic codeValid,
	input logic codeReady,
	input logic [7:0] opcode,
	input logic [7:0] operandOne,
	input logic [1:0] instLength,
	input logic [5:0] instCycles,
	input logic [2:0] regSel,
	input logic usesCarry,
	input logic busy,
	input logic instDone
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	logic take;
	assign take = codeValid && codeReady && !busy;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	op_capture_a: assert property (take |=> busy && opcode == $past(codeByte))
		else $error("opcode not captured at take");
	oper_clear_a: assert property (take |=> operandOne == 8'h00)
		else $error("operand byte not cleared at take");
	len_legal_a: assert property (busy |-> instLength != 2'h0)
		else $error("instruction length zero");
	cyc_range_a: assert property (busy |-> instCycles >= 6'h02 && instCycles <= 6'h20)
		else $error("cycle count out of range");
	done_pulse_a: assert property (instDone |=> !instDone)
		else $error("done longer than one cycle");
	exec_refuse_a: assert property (instDone |-> busy && !codeReady)
		else $error("byte accepted while executing");
	reg_field_a: assert property (busy |-> regSel == opcode[2:0])
		else $error("register select not from opcode");
	code_read_a: assert property (take && codeByte == 8'h93 |=> !instDone [*6] ##1 instDone)
		else $error("code read not eight cycles");
	rot_carry_a: assert property (take && codeByte inside {8'h23, 8'h03} |=> !usesCarry)
		else $error("plain rotate uses carry");
	done_bound_a: assert property (take |-> ##[1:40] instDone)
		else $error("instruction never completed");
endmodule : cid_decode_core_sva

bind cid_decode_core cid_decode_core_sva chk_u (.ref_clk, .rst, .codeByte, .codeValid, .codeReady,
	.opcode, .operandOne, .instLength, .instCycles, .regSel, .usesCarry, .busy, .instDone);

// ===== dv/cid_code_memory.sv
// program memory model offering code bytes in order
`timescale 1ns/1ps
module cid_code_memory (
	input logic ref_clk,
	input logic rst,
	input logic start,
	input logic slow,
	input logic [2:0] progLen,
	input logic codeReady,
	output logic [7:0] codeByte,
	output logic codeValid
);
	logic [7:0] mem [0:7];
	logic [2:0] ptrQ;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ptrQ <= 3'h0;
			codeValid <= 1'b0;
			codeByte <= 8'h00;
		end else if (start) begin
			ptrQ <= 3'h0;
			codeValid <= 1'b0;
		end else if (codeValid && codeReady) begin
			ptrQ <= ptrQ + 3'h1;
			codeValid <= !slow && (ptrQ + 3'h1 < progLen);
			codeByte <= slow ? ~codeByte : mem[ptrQ + 3'h1];
		end else if (!codeValid && ptrQ < progLen) begin
			codeValid <= 1'b1;
			codeByte <= mem[ptrQ];
		end else if (!codeValid) begin
			codeByte <= ~codeByte;
		end
	end
endmodule : cid_code_memory

// ===== dv/cid_decode_core_tb.sv
// self-checking testbench of the instruction decoder
`timescale 1ns/1ps
module cid_decode_core_tb;
	import cid_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic slow = 1'b0;
	logic wideMuldivSelect = 1'b0;
	logic longDivideSelect = 1'b0;
	logic [2:0] progLen = 3'h0;
	logic [7:0] codeByte, opcode, operandOne, operandTwo;
	logic codeValid, codeReady, indSel, usesCarry, busy, instDone;
	cid_op_t opKind;
	cid_am_t srcMode, dstMode;
	logic [LEN_W-1:0] instLength;
	logic [CYC_W-1:0] instCycles;
	logic [REG_W-1:0] regSel;
	int miscompares = 0;
	int comparisons = 0;
	int cyc = 0;
	cid_decode_core dut_u (.ref_clk, .rst, .codeByte, .codeValid, .codeReady, .wideMuldivSelect,
		.longDivideSelect, .opcode, .operandOne, .operandTwo, .opKind, .srcMode, .dstMode,
		.instLength, .instCycles, .regSel, .indSel, .usesCarry, .busy, .instDone);
	cid_code_memory mem_u (.ref_clk, .rst, .start, .slow, .progLen, .codeReady, .codeByte,
		.codeValid);
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) cyc <= cyc + 1;
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic ck(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : ck
	task automatic go(input logic [2:0] n);
		@(posedge ref_clk);
		progLen <= n;
		start <= 1'b1;
		@(posedge ref_clk);
		start <= 1'b0;
	endtask : go
	task automatic tk();
		int n;
		for (n = 0; n < 200; n++) begin
			@(negedge ref_clk);
			if (codeValid === 1'b1 && codeReady === 1'b1 && busy === 1'b0) break;
		end
		ck(8'(n < 200), 8'h01);
		@(negedge ref_clk);
	endtask : tk
	task automatic ex(input logic [7:0] op, input int len, input int cy, input cid_op_t kind);
		int k;
		int e;
		{mem_u.mem[0], mem_u.mem[1], mem_u.mem[2]} = {op, 16'h5AC3};
		go(3'(len));
		tk();
		e = slow ? 2 * len - 1 : len;
		e = (cy - 1 > e) ? cy - 1 : e;
		ck(8'(instLength), 8'(len));
		ck(8'(instCycles), 8'(cy));
		ck({3'h0, opKind}, {3'h0, kind});
		ck({5'h00, regSel}, {5'h00, op[2:0]});
		for (k = 1; instDone !== 1'b1 && k < 64; k++) begin
			@(negedge ref_clk);
		end
		ck(8'(k), 8'(e));
		ck(operandOne, len > 1 ? 8'h5A : 8'h00);
		ck(operandTwo, len > 2 ? 8'hC3 : 8'h00);
	endtask : ex
	task automatic wrap_up();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic sc_alu();
		ex(8'h2F, 1, 2, OP_ADD);
		ex(8'h25, 2, 2, OP_ADD);
		ex(8'h36, 1, 2, OP_ADDC);
		ex(8'h34, 2, 2, OP_ADDC);
		ex(8'h98, 1, 2, OP_SUBB);
		ex(8'h95, 2, 2, OP_SUBB);
		ex(8'h52, 2, 2, OP_ANL);
		ex(8'h53, 3, 4, OP_ANL);
		ex(8'h4F, 1, 2, OP_ORL);
		ex(8'h43, 3, 4, OP_ORL);
		ex(8'h62, 2, 2, OP_XRL);
		ex(8'h63, 3, 4, OP_XRL);
	endtask : sc_alu
	task automatic sc_move();
		ex(8'hE8, 1, 2, OP_MOV);
		ex(8'h74, 2, 2, OP_MOV);
		ex(8'hAF, 2, 4, OP_MOV);
		ex(8'h78, 2, 2, OP_MOV);
		ex(8'h8F, 2, 4, OP_MOV);
		ex(8'hA6, 2, 4, OP_MOV);
		ex(8'hF7, 1, 2, OP_MOV);
		@(posedge ref_clk) slow <= 1'b1;
		ex(8'h85, 3, 4, OP_MOV);
		ex(8'h75, 3, 4, OP_MOV);
		ex(8'h90, 3, 4, OP_MOV);
		@(posedge ref_clk) slow <= 1'b0;
	endtask : sc_move
	task automatic sc_long();
		ex(8'h93, 1, 8, OP_MOVC);
		ex(8'h83, 1, 8, OP_MOVC);
		ex(8'hE3, 1, 8, OP_MOVX);
		ex(8'hF0, 1, 8, OP_MOVX);
		ex(8'hA4, 1, 8, OP_MUL);
		@(posedge ref_clk) wideMuldivSelect <= 1'b1;
		ex(8'hA4, 1, 16, OP_MUL);
		ex(8'h84, 1, 16, OP_DIV);
		@(posedge ref_clk) longDivideSelect <= 1'b1;
		ex(8'h84, 1, 32, OP_DIV);
		@(posedge ref_clk) wideMuldivSelect <= 1'b0;
		ex(8'h84, 1, 8, OP_DIV);
	endtask : sc_long
	task automatic sc_misc();
		ex(8'hC0, 2, 4, OP_PUSH);
		ex(8'hD0, 2, 4, OP_POP);
		ex(8'hCF, 1, 2, OP_XCH);
		ex(8'hD7, 1, 2, OP_XCHD);
		ex(8'hB0, 2, 4, OP_ANLN);
		ex(8'hA0, 2, 4, OP_ORLN);
		ex(8'hA2, 2, 2, OP_MOV);
		ex(8'h92, 2, 4, OP_MOV);
	endtask : sc_misc
	task automatic sc_modes();
		ex(8'h27, 1, 2, OP_ADD);
		ck({srcMode, dstMode}, {AM_IND, AM_ACC});
		ck({7'h00, indSel}, 8'h01);
		ex(8'hF6, 1, 2, OP_MOV);
		ck({srcMode, dstMode}, {AM_ACC, AM_IND});
		ck({7'h00, indSel}, 8'h00);
		ex(8'h85, 3, 4, OP_MOV);
		ck({srcMode, dstMode}, {AM_DIR, AM_DIR});
		ex(8'hE0, 1, 8, OP_MOVX);
		ck({srcMode, dstMode}, {AM_EXT_DPTR, AM_ACC});
		ex(8'hC0, 2, 4, OP_PUSH);
		ck({srcMode, dstMode}, {AM_DIR, AM_STACK});
		ex(8'h92, 2, 4, OP_MOV);
		ck({srcMode, dstMode}, {AM_CARRY, AM_BIT});
	endtask : sc_modes
	task automatic sc_b2b();
		int t;
		{mem_u.mem[0], mem_u.mem[1], mem_u.mem[2], mem_u.mem[3]} = 32'h23330313;
		go(3'h4);
		for (int i = 0; i < 4; i++) begin
			tk();
			ck(opcode, 8'(32'h23330313 >> (24 - 8 * i)));
			ck({7'h00, usesCarry}, {7'h00, 1'(i)});
			ck(8'(i == 0 ? 2 : cyc - t), 8'h02);
			t = cyc;
		end
	endtask : sc_b2b
	task automatic sc_rst();
		mem_u.mem[0] = 8'h93;
		go(3'h1);
		tk();
		@(posedge ref_clk);
		rst <= 1'b1;
		progLen <= 3'h0;
		@(negedge ref_clk);
		ck({instLength, instCycles}, 8'h42);
		ck({5'h00, codeReady, busy, instDone}, 8'h04);
		@(posedge ref_clk);
		rst <= 1'b0;
		ex(8'h24, 2, 2, OP_ADD);
	endtask : sc_rst
	initial begin
		#(100 * 20000);
		miscompares++;
		wrap_up();
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		sc_alu();
		sc_move();
		sc_long();
		sc_misc();
		sc_modes();
		sc_b2b();
		sc_rst();
		wrap_up();
	end
endmodule : cid_decode_core_tb
